/* design/smls_pkg.sv */
// Shared constants for the installation test mode link sequencer
package smls_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int HOLD_MS = 3000;
    localparam int WAKE_MS = 1000;
    localparam int MEAS_S = 180;
    localparam int CONN_TMO_S = 300;
    localparam int RETRY_S = 120;
    localparam int RESULT_S = 300;
    localparam int MAX_TRIES = 2;
    localparam int SEGMENTS = 8;
    localparam int TICK_CYC = CLK_HZ / 1000;
    localparam int HOLD_TICKS = HOLD_MS;
    localparam int WAKE_TICKS = WAKE_MS;
    localparam int SEG_TICKS = (HOLD_TICKS + SEGMENTS - 1) / SEGMENTS;
    localparam int SEC_TICKS = 1000;
    localparam logic [1:0] DISP_IDLE = 2'h0;
    localparam logic [1:0] DISP_CONNECT = 2'h1;
    localparam logic [1:0] DISP_SYNC = 2'h2;
    localparam logic [1:0] DISP_MEASURE = 2'h3;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_OK = 2'h1;
    localparam logic [1:0] RES_FAIL = 2'h2;
endpackage

/* design/smls_tick.sv */
// Millisecond tick divider
`timescale 1ns/1ps
module smls_tick #(
    parameter int DIV = 40000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    output logic tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    always_comb begin
        if (cnt_r >= 32'(DIV - 1)) begin
            cnt_nxt = 32'h0;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = ce && (cnt_r >= 32'(DIV - 1));
endmodule

/* design/smls_seq.sv */
// Installation test mode sequencer with connection retry handling
// How it works
// [R1] Test mode starts only after reed switch held continuously three seconds.
// [R2] Hold progress lights segments one by one; all lit means mode active.
// [R3] On entry, connect to server and report test mode activation first.
// [R4] Each connection shows connect phase, then data synchronisation phase.
// [R5] After report, disconnect and sample signal level up to three minutes.
// [R6] Sensor values are captured throughout the measurement window.
// [R7] Remaining window seconds are counted down, shown and offered for report.
// [R8] Window expiry opens second connection and sends level and sensor data.
// [R9] Second connection not up within five minutes ends test mode failed.
// [R10] After abort wait two minutes before retry; at most two attempts.
// [R11] A one second reed press switches the display back on.
// [R12] Result stays on display for five minutes after test mode ends.
// [R13] Afterwards return to normal operation with no operator input.
`timescale 1ns/1ps
module smls_seq #(
    parameter int TICK_DIV = smls_pkg::TICK_CYC,
    parameter int SEC_TICKS = smls_pkg::SEC_TICKS,
    parameter int LVL_W = 8,
    parameter int SNS_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reed,
    input wire logic link_up,
    input wire logic link_abort,
    input wire logic sync_done,
    input wire logic [LVL_W-1:0] sig_level,
    input wire logic [SNS_W-1:0] sensor_val,
    output logic link_req,
    output logic send_report,
    output logic send_results,
    output logic [1:0] disp_phase,
    output logic [smls_pkg::SEGMENTS-1:0] disp_segments,
    output logic disp_on,
    output logic [8:0] remain_s,
    output logic [LVL_W-1:0] min_level,
    output logic [LVL_W-1:0] max_level,
    output logic [SNS_W-1:0] sensor_last,
    output logic sample_strobe,
    output logic [1:0] result,
    output logic test_active,
    output logic normal_mode
);
    typedef enum {
        SMLS_NORMAL, SMLS_CONN1, SMLS_SYNC1, SMLS_MEASURE,
        SMLS_CONN2, SMLS_SYNC2, SMLS_WAIT, SMLS_RESULT
    } smls_state_t;

    logic tick;
    smls_state_t st_r, st_nxt;
    logic [15:0] ms_r, ms_nxt;
    logic [15:0] hold_r, hold_nxt;
    logic [8:0] sec_r, sec_nxt;
    logic [8:0] tmo_r, tmo_nxt;
    logic [1:0] tries_r, tries_nxt;
    logic disp_r, disp_nxt;
    logic [1:0] res_r, res_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [LVL_W-1:0] min_r, min_nxt, max_r, max_nxt;
    logic [SNS_W-1:0] sns_r, sns_nxt;
    logic smp_r, smp_nxt;
    logic conn2_r, conn2_nxt;
    logic sec_tick;
    logic second_conn;

    smls_tick #(.DIV(TICK_DIV)) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .tick(tick)
    );

    assign sec_tick = tick && (ms_r == 16'(SEC_TICKS - 1));
    assign second_conn = (st_r == SMLS_CONN2) || (st_r == SMLS_SYNC2);

    always_comb begin
        st_nxt = st_r;
        ms_nxt = ms_r;
        hold_nxt = hold_r;
        sec_nxt = sec_r;
        tmo_nxt = tmo_r;
        tries_nxt = tries_r;
        disp_nxt = disp_r;
        res_nxt = res_r;
        ph_nxt = ph_r;
        min_nxt = min_r;
        max_nxt = max_r;
        sns_nxt = sns_r;
        conn2_nxt = conn2_r;
        smp_nxt = 1'b0;
        if (tick) begin
            ms_nxt = sec_tick ? 16'h0 : ms_r + 16'h1;
        end
        // Hold counter saturates; any release restarts it
        if (!reed) begin
            hold_nxt = 16'h0;
        end else if (tick && hold_r != 16'hFFFF) begin
            hold_nxt = hold_r + 16'h1;
        end
        unique case (st_r)
            SMLS_NORMAL: begin
                if (reed && hold_r >= 16'(smls_pkg::HOLD_TICKS)) begin
                    st_nxt = SMLS_CONN1; // [R1] [R3]
                    ph_nxt = smls_pkg::DISP_CONNECT; // [R4]
                    tries_nxt = 2'h1;
                    tmo_nxt = 9'(smls_pkg::CONN_TMO_S);
                    res_nxt = smls_pkg::RES_NONE;
                    disp_nxt = 1'b1;
                    hold_nxt = 16'h0;
                    conn2_nxt = 1'b0;
                end
            end
            SMLS_CONN1, SMLS_CONN2: begin
                if (link_abort) begin
                    st_nxt = SMLS_WAIT;
                    sec_nxt = 9'(smls_pkg::RETRY_S); // [R10]
                end else if (link_up) begin
                    st_nxt = (st_r == SMLS_CONN1) ? SMLS_SYNC1 : SMLS_SYNC2;
                    ph_nxt = smls_pkg::DISP_SYNC; // [R4]
                end
            end
            SMLS_SYNC1: begin
                if (link_abort) begin
                    st_nxt = SMLS_WAIT;
                    sec_nxt = 9'(smls_pkg::RETRY_S); // [R10]
                end else if (sync_done) begin
                    st_nxt = SMLS_MEASURE; // [R5]
                    ph_nxt = smls_pkg::DISP_MEASURE;
                    sec_nxt = 9'(smls_pkg::MEAS_S);
                    min_nxt = '1;
                    max_nxt = '0;
                end
            end
            SMLS_MEASURE: begin
                if (sec_tick) begin
                    smp_nxt = 1'b1;
                    sns_nxt = sensor_val; // [R6]
                    if (sig_level < min_r) begin
                        min_nxt = sig_level; // [R5]
                    end
                    if (sig_level > max_r) begin
                        max_nxt = sig_level;
                    end
                    if (sec_r <= 9'h1) begin
                        sec_nxt = 9'h0;
                        st_nxt = SMLS_CONN2; // [R8]
                        conn2_nxt = 1'b1;
                        ph_nxt = smls_pkg::DISP_CONNECT;
                        tries_nxt = 2'h1;
                        tmo_nxt = 9'(smls_pkg::CONN_TMO_S);
                    end else begin
                        sec_nxt = sec_r - 9'h1; // [R7]
                    end
                end
            end
            SMLS_SYNC2: begin
                if (link_abort) begin
                    st_nxt = SMLS_WAIT;
                    sec_nxt = 9'(smls_pkg::RETRY_S); // [R10]
                end else if (sync_done) begin
                    st_nxt = SMLS_RESULT;
                    res_nxt = smls_pkg::RES_OK;
                    sec_nxt = 9'(smls_pkg::RESULT_S); // [R12]
                    ph_nxt = smls_pkg::DISP_IDLE;
                    disp_nxt = 1'b1;
                end
            end
            SMLS_WAIT: begin
                if (tries_r >= 2'(smls_pkg::MAX_TRIES)) begin
                    // Out of attempts: the attempt budget ends the mode early
                    st_nxt = SMLS_RESULT; // [R10]
                    res_nxt = smls_pkg::RES_FAIL;
                    sec_nxt = 9'(smls_pkg::RESULT_S);
                    ph_nxt = smls_pkg::DISP_IDLE;
                    disp_nxt = 1'b1;
                end else if (sec_tick) begin
                    if (sec_r <= 9'h1) begin
                        tries_nxt = tries_r + 2'h1; // [R10]
                        st_nxt = conn2_r ? SMLS_CONN2 : SMLS_CONN1;
                        ph_nxt = smls_pkg::DISP_CONNECT;
                    end else begin
                        sec_nxt = sec_r - 9'h1;
                    end
                end
            end
            SMLS_RESULT: begin
                if (sec_tick) begin
                    if (sec_r <= 9'h1) begin
                        st_nxt = SMLS_NORMAL; // [R13]
                        res_nxt = smls_pkg::RES_NONE;
                        disp_nxt = 1'b0; // [R12]
                    end else begin
                        sec_nxt = sec_r - 9'h1;
                    end
                end
            end
        endcase
        // After the state logic, so a press outweighs the end-of-result clear
        if (reed && hold_r >= 16'(smls_pkg::WAKE_TICKS)) begin
            disp_nxt = 1'b1; // [R11]
        end
        // Second connection has a hard timeout across its retries
        if (second_conn || (st_r == SMLS_WAIT && conn2_r)) begin
            if (sec_tick && st_r != SMLS_NORMAL) begin
                if (tmo_r <= 9'h1) begin
                    st_nxt = SMLS_RESULT; // [R9]
                    res_nxt = smls_pkg::RES_FAIL;
                    sec_nxt = 9'(smls_pkg::RESULT_S);
                    ph_nxt = smls_pkg::DISP_IDLE;
                    disp_nxt = 1'b1;
                    tmo_nxt = 9'h0;
                end else begin
                    tmo_nxt = tmo_r - 9'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= SMLS_NORMAL;
            ms_r <= 16'h0;
            hold_r <= 16'h0;
            sec_r <= 9'h0;
            tmo_r <= 9'h0;
            tries_r <= 2'h0;
            disp_r <= 1'b0;
            res_r <= smls_pkg::RES_NONE;
            ph_r <= smls_pkg::DISP_IDLE;
            min_r <= '0;
            max_r <= '0;
            sns_r <= '0;
            smp_r <= 1'b0;
            conn2_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            ms_r <= ms_nxt;
            hold_r <= hold_nxt;
            sec_r <= sec_nxt;
            tmo_r <= tmo_nxt;
            tries_r <= tries_nxt;
            disp_r <= disp_nxt;
            res_r <= res_nxt;
            ph_r <= ph_nxt;
            min_r <= min_nxt;
            max_r <= max_nxt;
            sns_r <= sns_nxt;
            smp_r <= smp_nxt;
            conn2_r <= conn2_nxt;
        end
    end

    // Segments fill as hold time accumulates; only shown before mode entry
    always_comb begin
        disp_segments = '0;
        for (int i = 0; i < smls_pkg::SEGMENTS; i++) begin
            if (st_r == SMLS_NORMAL && hold_r >= 16'((i + 1) * smls_pkg::SEG_TICKS)) begin
                disp_segments[i] = 1'b1; // [R2]
            end
        end
    end

    assign link_req = (st_r == SMLS_CONN1) || (st_r == SMLS_CONN2);
    assign send_report = (st_r == SMLS_SYNC1); // [R3]
    assign send_results = (st_r == SMLS_SYNC2); // [R8]
    assign disp_phase = (st_r == SMLS_WAIT) ? smls_pkg::DISP_IDLE : ph_r;
    assign disp_on = disp_r;
    assign remain_s = (st_r == SMLS_MEASURE) ? sec_r : 9'h0; // [R7]
    assign min_level = min_r;
    assign max_level = max_r;
    assign sensor_last = sns_r;
    assign sample_strobe = smp_r;
    assign result = res_r;
    assign test_active = (st_r != SMLS_NORMAL) && (st_r != SMLS_RESULT);
    assign normal_mode = (st_r == SMLS_NORMAL) || (st_r == SMLS_RESULT); // [R13]
endmodule

/* test/smls_seq_sva.sv */
// Port assertions for the test mode sequencer
`timescale 1ns/1ps
module smls_seq_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reed,
    input wire logic link_up,
    input wire logic sync_done,
    input wire logic link_req,
    input wire logic send_report,
    input wire logic send_results,
    input wire logic [1:0] disp_phase,
    input wire logic [smls_pkg::SEGMENTS-1:0] disp_segments,
    input wire logic [8:0] remain_s,
    input wire logic sample_strobe,
    input wire logic [1:0] result,
    input wire logic normal_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_report_done;
        send_report && sync_done;
    endsequence
    sequence s_results_done;
        send_results && sync_done;
    endsequence
    a_entry_hold: assert property ($rose(link_req) && $past(normal_mode) |-> $past(reed))
        else $error("link request without reed hold");
    a_segs_idle: assert property (disp_segments != '0 |-> normal_mode)
        else $error("segments lit outside idle");
    a_conn_sync: assert property (link_req && link_up |=> (send_report || send_results)
        && disp_phase == smls_pkg::DISP_SYNC) else $error("no sync after link up");
    a_conn_phase: assert property (link_req |-> disp_phase == smls_pkg::DISP_CONNECT)
        else $error("connect phase not shown");
    a_meas_start: assert property (s_report_done |=> disp_phase == smls_pkg::DISP_MEASURE
        && remain_s == 9'h0B4 && !link_req) else $error("window did not start");
    a_count_down: assert property (disp_phase == smls_pkg::DISP_MEASURE
        && $past(disp_phase) == smls_pkg::DISP_MEASURE && $changed(remain_s)
        |-> remain_s == $past(remain_s) - 9'h001) else $error("countdown step wrong");
    a_strobe_one: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe too long");
    a_expiry_conn: assert property ($past(disp_phase) == smls_pkg::DISP_MEASURE
        && disp_phase != smls_pkg::DISP_MEASURE |-> link_req && remain_s == 9'h000)
        else $error("window end without reconnect");
    a_result_ok: assert property (s_results_done |=> result == smls_pkg::RES_OK)
        else $error("result not ok after transfer");
    a_normal_quiet: assert property (normal_mode |-> !link_req
        && disp_phase == smls_pkg::DISP_IDLE) else $error("activity in normal mode");
endmodule
bind smls_seq smls_seq_sva smls_seq_sva_i (.mclk(mclk), .rst_n(rst_n), .reed(reed),
    .link_up(link_up), .sync_done(sync_done), .link_req(link_req),
    .send_report(send_report), .send_results(send_results), .disp_phase(disp_phase),
    .disp_segments(disp_segments), .remain_s(remain_s), .sample_strobe(sample_strobe),
    .result(result), .normal_mode(normal_mode));

/* test/smls_modem.sv */
// Behavioural modem and server answering connection and sync requests
`timescale 1ns/1ps
module smls_modem (
    input wire logic mclk,
    input wire logic link_req,
    input wire logic send_report,
    input wire logic send_results,
    input wire logic abort_en,
    input wire logic mute,
    input wire logic [7:0] dly,
    output logic link_up = 1'b0,
    output logic link_abort = 1'b0,
    output logic sync_done = 1'b0
);
    logic [7:0] cnt = 8'h00;
    // Answers come as one-cycle pulses, so a missed pulse is never hidden by a level
    always @(posedge mclk) begin
        link_up <= 1'b0;
        link_abort <= 1'b0;
        sync_done <= 1'b0;
        // A muted modem never answers, which models a site out of coverage
        if (mute || !(link_req || send_report || send_results) || link_up || link_abort
            || sync_done) begin
            cnt <= 8'h00;
        end else if (cnt == dly) begin
            cnt <= 8'h00;
            if (link_req) begin
                link_abort <= abort_en;
                link_up <= !abort_en;
            end else begin
                sync_done <= 1'b1;
            end
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

/* test/smls_seq_test.sv */
// Scenario testbench for the test mode sequencer
`timescale 1ns/1ps
module smls_seq_test;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reed = 1'b0, abort_en = 1'b0, mute = 1'b0;
    logic [7:0] dly = 8'h03, sig_level = 8'h30;
    logic [15:0] sensor_val = 16'h1234;
    logic link_up, link_abort, sync_done, link_req, send_report, send_results;
    logic disp_on, sample_strobe, test_active, normal_mode;
    logic [1:0] disp_phase, result;
    logic [7:0] disp_segments, min_level, max_level;
    logic [8:0] remain_s;
    logic [15:0] sensor_last;
    int bad_count = 0;
    int num_checks = 0;
    // Short time bases keep a full pass within reach: 1 tick = 4 cycles, 1 s = 40 cycles
    smls_seq #(.TICK_DIV(4), .SEC_TICKS(10)) smls_seq_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .reed(reed), .link_up(link_up), .link_abort(link_abort), .sync_done(sync_done),
        .sig_level(sig_level), .sensor_val(sensor_val), .link_req(link_req),
        .send_report(send_report), .send_results(send_results), .disp_phase(disp_phase),
        .disp_segments(disp_segments), .disp_on(disp_on), .remain_s(remain_s),
        .min_level(min_level), .max_level(max_level), .sensor_last(sensor_last),
        .sample_strobe(sample_strobe), .result(result), .test_active(test_active),
        .normal_mode(normal_mode));
    smls_modem smls_modem_i (.mclk(mclk), .link_req(link_req), .send_report(send_report),
        .send_results(send_results), .abort_en(abort_en), .mute(mute), .dly(dly),
        .link_up(link_up),
        .link_abort(link_abort), .sync_done(sync_done));
    initial forever #12.5 mclk = ~mclk;
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk_range(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic hit(input int sel);
        case (sel)
            0: hit = link_req === 1'b1;
            1: hit = link_req === 1'b0;
            2: hit = disp_phase === smls_pkg::DISP_MEASURE;
            3: hit = result !== smls_pkg::RES_NONE;
            default: hit = normal_mode === 1'b1 && result === smls_pkg::RES_NONE;
        endcase
    endfunction
    task wait_on(input int sel, input int lim, output int n);
        n = 0;
        while (!hit(sel) && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_range("wait condition", sel, sel, hit(sel) ? sel : -1);
    endtask
    task enter(output int n);
        @(posedge mclk) reed <= 1'b1;
        #1;
        wait_on(0, 12100, n);
        @(posedge mclk) reed <= 1'b0;
        #1;
    endtask
    task t_short;
        @(posedge mclk) reed <= 1'b1;
        cyc(4400);
        #1;
        chk("segments lit", 16'h0000, {15'h0, disp_segments == 8'h00});
        chk("segments full", 16'h0000, {15'h0, disp_segments == 8'hFF});
        @(posedge mclk) reed <= 1'b0;
        cyc(2);
        #1;
        chk("disp_on", 16'h0001, {15'h0, disp_on});
        chk("link_req", 16'h0000, {15'h0, link_req});
        $display("short press test done");
    endtask
    task t_success;
        int n;
        enter(n);
        chk_range("hold cycles", 11990, 12010, n);
        wait_on(2, 60, n);
        chk("remain_s", 16'h00B4, {7'h0, remain_s});
        chk("test_active", 16'h0001, {15'h0, test_active});
        fork
            wait_on(0, 7300, n);
            begin
                cyc(2000);
                sig_level <= 8'h50;
                cyc(2000);
                sig_level <= 8'h10;
                sensor_val <= 16'hA5C3;
            end
        join
        chk_range("window cycles", 7150, 7250, n);
        chk("min_level", 16'h0010, {8'h0, min_level});
        chk("max_level", 16'h0050, {8'h0, max_level});
        chk("sensor_last", 16'hA5C3, sensor_last);
        wait_on(3, 60, n);
        chk("result ok", {14'h0, smls_pkg::RES_OK}, {14'h0, result});
        wait_on(4, 12100, n);
        chk_range("result hold", 11950, 12050, n);
        chk("disp_on", 16'h0000, {15'h0, disp_on});
        $display("success test done");
    endtask
    task t_fail;
        int n;
        abort_en <= 1'b1;
        dly <= 8'hC8;
        enter(n);
        wait_on(1, 300, n);
        wait_on(0, 5000, n);
        chk_range("retry gap", 4780, 4820, n);
        wait_on(3, 300, n);
        chk("result fail", {14'h0, smls_pkg::RES_FAIL}, {14'h0, result});
        chk("test_active", 16'h0000, {15'h0, test_active});
        wait_on(4, 12100, n);
        chk_range("fail hold", 11950, 12050, n);
        abort_en <= 1'b0;
        $display("abort test done");
    endtask
    task t_timeout;
        int n, total;
        dly <= 8'h03;
        enter(n);
        wait_on(2, 60, n);
        abort_en <= 1'b1;
        wait_on(0, 7300, n);
        wait_on(1, 300, n);
        total = n;
        abort_en <= 1'b0;
        mute <= 1'b1;
        wait_on(0, 5000, n);
        total += n;
        chk_range("second retry gap", 4780, 4820, n);
        wait_on(3, 12100, n);
        total += n;
        chk_range("link timeout", 11950, 12050, total);
        chk("result timeout", {14'h0, smls_pkg::RES_FAIL}, {14'h0, result});
        mute <= 1'b0;
        $display("timeout test done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(2);
        t_short;
        t_success;
        t_fail;
        t_timeout;
        final_report;
    end
    // Whole run needs about 96000 cycles
    initial begin
        cyc(99000);
        bad_count++;
        $display("unexpected run length expected 96000 seen 99000");
        final_report;
    end
endmodule
